/* rss_pkg.sv */
// Package for the reclose state sequencer: register map, field layout, reset values, states.
// Assumes a 50 MHz system clock and a power-system cycle tick from elsewhere in the chip.
package rss_pkg;

   // -----------------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------------
   localparam logic [7:0] RSS_CTRL_OFS = 8'h00;
   localparam logic [7:0] RSS_OI1_OFS = 8'h04;
   localparam logic [7:0] RSS_OI2_OFS = 8'h08;
   localparam logic [7:0] RSS_OI3_OFS = 8'h0C;
   localparam logic [7:0] RSS_OI4_OFS = 8'h10;
   localparam logic [7:0] RSS_RST_OFS = 8'h14;
   localparam logic [7:0] RSS_STAT_OFS = 8'h18;

   // -----------------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------------
   localparam int RSS_CTRL_CLOSE_BIT = 0;
   localparam int RSS_CTRL_MASK_LSB = 8;
   localparam int RSS_STAT_SHOT_LSB = 8;
   localparam logic [4:0] RSS_MASK_RST = 5'h0A;
   localparam logic [15:0] RSS_OI1_RST = 16'h003C;
   localparam logic [15:0] RSS_OI2_RST = 16'h0258;
   localparam logic [15:0] RSS_OI3_RST = 16'h0384;
   localparam logic [15:0] RSS_OI4_RST = 16'h0000;
   localparam logic [15:0] RSS_RSTI_RST = 16'h0708;
   localparam logic [2:0] RSS_SHOT_MAX = 3'h4;
   localparam logic [1:0] RSS_RESP_OKAY = 2'h0;
   localparam logic [1:0] RSS_RESP_SLVERR = 2'h2;

   // -----------------------------------------------------------------------
   // Sequencer states
   // -----------------------------------------------------------------------
   typedef enum logic [1:0] {
      RSS_LOCKOUT,
      RSS_RESET,
      RSS_CYCLE
   } rss_state_t;

endpackage : rss_pkg

/* rss_sequencer.sv */
// Reclose state sequencer with its AXI4-Lite register slave.
// Assumes breaker inputs are raw pins (synchronised here) and the cycle tick is on clk_sys.
//
// How it works
// - Breaker open in lockout keeps lockout bit
// - Reset only after full closed reset interval
// - Reset timer starts on close; lockout holds
// - Timer expiry: reset set, lockout cleared together
// - Open timer needs open, no trip, interval left
// - Open interval expiry asserts close output
// - Trip output follows trip condition directly
// - Intervals used in order; lockout after last
// - Trip in reset enters reclose cycle
// - Closed reset interval from cycle gives reset
// - Intervals exhausted and open gives lockout
// - Nonzero settings count; zero ends list
// - Expiry increments shot, then closes breaker
// - Shot count zero in reset state
// - Shot bit is mask bit of shot
// - Return to reset clears shot count
// - Lockout keeps last shot and shot bit
// - Close command or direct close closes
// - Permit removed forces lockout
`timescale 1ns/1ps

module rss_sequencer #(
   parameter int TW = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Field inputs (asynchronous pins)
   input wire logic breaker_closed_input,
   input wire logic direct_close_function,
   input wire logic autoclose_permit,
   input wire logic fault_release_terms,
   // Cycle tick from the same clock domain
   input wire logic cycle_tick,
   // Breaker coils and state bits
   output logic trip_out,
   output logic close_out,
   output logic reset_state_bit,
   output logic cycle_state_bit,
   output logic lockout_state_bit,
   output logic shot_indicator_bit,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // -----------------------------------------------------------------------
   // State record
   // -----------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      rss_pkg::rss_state_t st;
      logic [TW-1:0] rst_cnt;
      logic [TW-1:0] oi_cnt;
      logic oi_run;
      logic [2:0] shot;
      logic [3:0][TW-1:0] oi_set;
      logic [TW-1:0] rsti_set;
      logic [4:0] mask;
      logic close_cmd;
      logic trip;
      logic close;
      logic rs;
      logic cy;
      logic lo;
      logic sh;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } rss_state_rec_t;

   rss_state_rec_t q_reg;
   rss_state_rec_t q_next;

   // Interval setting for a shot index; zero past the end of the table.
   function automatic logic [TW-1:0] oi_of(input logic [3:0][TW-1:0] t, input logic [2:0] i);
      oi_of = (i < 3'h4) ? t[i[1:0]] : '0;
   endfunction : oi_of

   // Mask position zero is the leftmost digit, so shot four is bit 0.
   function automatic logic mask_bit(input logic [4:0] m, input logic [2:0] s);
      mask_bit = (s <= rss_pkg::RSS_SHOT_MAX) ? m[3'h4 - s] : 1'b0;
   endfunction : mask_bit

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            merge[8*b +: 8] = d[8*b +: 8];
         end
      end
   endfunction : merge

   logic brk_closed;
   logic dc_in;
   logic permit;
   logic trip_cond;
   logic [TW-1:0] oi_now;
   logic wr_go;
   logic [31:0] wr_val;
   logic [31:0] stat_word;

   assign brk_closed = q_reg.s2[0];
   assign dc_in = q_reg.s2[1];
   assign permit = q_reg.s2[2];
   assign trip_cond = q_reg.s2[3];
   assign oi_now = oi_of(q_reg.oi_set, q_reg.shot);
   assign wr_go = q_reg.aw_got && q_reg.w_got && !q_reg.bvalid;
   assign stat_word = {21'h0, q_reg.shot, 3'h0,
                       q_reg.sh, q_reg.lo, q_reg.cy, q_reg.rs, q_reg.trip};

   // -----------------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------------
   always_comb begin
      q_next = q_reg;
      wr_val = 32'h0;
      q_next.s1 = {fault_release_terms, autoclose_permit, direct_close_function,
                   breaker_closed_input};
      q_next.s2 = q_reg.s1;
      q_next.close_cmd = 1'b0;

      // Register bus: write address and data in either order, then one response.
      if (s_axi_awvalid && !q_reg.aw_got) begin
         q_next.aw_got = 1'b1;
         q_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q_reg.w_got) begin
         q_next.w_got = 1'b1;
         q_next.wdata = s_axi_wdata;
         q_next.wstrb = s_axi_wstrb;
      end
      if (wr_go) begin
         q_next.aw_got = 1'b0;
         q_next.w_got = 1'b0;
         q_next.bvalid = 1'b1;
         q_next.bresp = rss_pkg::RSS_RESP_OKAY;
         case (q_reg.awaddr)
            rss_pkg::RSS_CTRL_OFS: begin
               wr_val = merge({19'h0, q_reg.mask, 8'h0}, q_reg.wdata, q_reg.wstrb);
               q_next.mask = wr_val[rss_pkg::RSS_CTRL_MASK_LSB +: 5];
               q_next.close_cmd = wr_val[rss_pkg::RSS_CTRL_CLOSE_BIT];
            end
            rss_pkg::RSS_OI1_OFS, rss_pkg::RSS_OI2_OFS, rss_pkg::RSS_OI3_OFS,
            rss_pkg::RSS_OI4_OFS: begin
               wr_val = merge({{(32-TW){1'b0}}, q_reg.oi_set[q_reg.awaddr[3:2] - 2'h1]},
                              q_reg.wdata, q_reg.wstrb);
               q_next.oi_set[q_reg.awaddr[3:2] - 2'h1] = wr_val[TW-1:0];
            end
            rss_pkg::RSS_RST_OFS: begin
               wr_val = merge({{(32-TW){1'b0}}, q_reg.rsti_set}, q_reg.wdata, q_reg.wstrb);
               q_next.rsti_set = wr_val[TW-1:0];
            end
            rss_pkg::RSS_STAT_OFS: begin
               q_next.bresp = rss_pkg::RSS_RESP_OKAY;
            end
            default: begin
               q_next.bresp = rss_pkg::RSS_RESP_SLVERR;
            end
         endcase
      end
      if (q_reg.bvalid && s_axi_bready) begin
         q_next.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !q_reg.rvalid) begin
         q_next.rvalid = 1'b1;
         q_next.rresp = rss_pkg::RSS_RESP_OKAY;
         case (s_axi_araddr)
            rss_pkg::RSS_CTRL_OFS: q_next.rdata = {19'h0, q_reg.mask, 8'h0};
            rss_pkg::RSS_OI1_OFS: q_next.rdata = {{(32-TW){1'b0}}, q_reg.oi_set[0]};
            rss_pkg::RSS_OI2_OFS: q_next.rdata = {{(32-TW){1'b0}}, q_reg.oi_set[1]};
            rss_pkg::RSS_OI3_OFS: q_next.rdata = {{(32-TW){1'b0}}, q_reg.oi_set[2]};
            rss_pkg::RSS_OI4_OFS: q_next.rdata = {{(32-TW){1'b0}}, q_reg.oi_set[3]};
            rss_pkg::RSS_RST_OFS: q_next.rdata = {{(32-TW){1'b0}}, q_reg.rsti_set};
            rss_pkg::RSS_STAT_OFS: q_next.rdata = stat_word;
            default: begin
               q_next.rdata = 32'h0;
               q_next.rresp = rss_pkg::RSS_RESP_SLVERR;
            end
         endcase
      end else if (q_reg.rvalid && s_axi_rready) begin
         q_next.rvalid = 1'b0;
      end

      // Trip follows the condition through the input synchroniser plus one output register.
      q_next.trip = trip_cond;
      // Close is held until the breaker reports closed so a short pulse cannot be lost.
      if (q_reg.close_cmd || dc_in) begin
         q_next.close = 1'b1;
      end else if (brk_closed) begin
         q_next.close = 1'b0;
      end

      // Reset interval timer runs only while the breaker stays closed.
      if (!brk_closed || q_reg.st == rss_pkg::RSS_RESET) begin
         q_next.rst_cnt = '0;
      end else if (cycle_tick && q_reg.rst_cnt < q_reg.rsti_set) begin
         q_next.rst_cnt = q_reg.rst_cnt + 1'b1;
      end

      // Open interval timer starts when open, trip gone and an interval remains.
      if (!brk_closed && !trip_cond && oi_now != '0 && q_reg.st == rss_pkg::RSS_CYCLE) begin
         q_next.oi_run = 1'b1;
         if (cycle_tick) begin
            q_next.oi_cnt = q_reg.oi_cnt + 1'b1;
         end
      end else begin
         q_next.oi_run = 1'b0;
         q_next.oi_cnt = '0;
      end

      case (q_reg.st)
         rss_pkg::RSS_LOCKOUT: begin
            if (brk_closed && q_reg.rst_cnt >= q_reg.rsti_set && permit) begin
               q_next.st = rss_pkg::RSS_RESET;
               q_next.shot = 3'h0;
            end
         end
         rss_pkg::RSS_RESET: begin
            q_next.shot = 3'h0;
            if (trip_cond) begin
               q_next.st = rss_pkg::RSS_CYCLE;
            end
         end
         rss_pkg::RSS_CYCLE: begin
            if (brk_closed && q_reg.rst_cnt >= q_reg.rsti_set) begin
               q_next.st = rss_pkg::RSS_RESET;
               q_next.shot = 3'h0;
            end else if (!brk_closed && oi_now == '0 && !q_reg.close) begin
               // A reclose still waiting for the breaker must land before lockout is judged.
               q_next.st = rss_pkg::RSS_LOCKOUT;
            end else if (q_reg.oi_run && q_reg.oi_cnt >= oi_now) begin
               q_next.shot = q_reg.shot + 1'b1;
               q_next.close = 1'b1;
               q_next.oi_cnt = '0;
               q_next.oi_run = 1'b0;
            end
         end
         default: begin
            q_next.st = rss_pkg::RSS_LOCKOUT;
         end
      endcase
      if (!permit) begin
         q_next.st = rss_pkg::RSS_LOCKOUT;
      end

      q_next.rs = (q_next.st == rss_pkg::RSS_RESET);
      q_next.cy = (q_next.st == rss_pkg::RSS_CYCLE);
      q_next.lo = (q_next.st == rss_pkg::RSS_LOCKOUT);
      q_next.sh = mask_bit(q_reg.mask, q_next.shot);
   end

   // -----------------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q_reg <= '0;
         q_reg.st <= rss_pkg::RSS_LOCKOUT;
         q_reg.lo <= 1'b1;
         q_reg.mask <= rss_pkg::RSS_MASK_RST;
         q_reg.oi_set <= {rss_pkg::RSS_OI4_RST, rss_pkg::RSS_OI3_RST,
                          rss_pkg::RSS_OI2_RST, rss_pkg::RSS_OI1_RST};
         q_reg.rsti_set <= rss_pkg::RSS_RSTI_RST;
         q_reg.sh <= 1'b0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign trip_out = q_reg.trip;
   assign close_out = q_reg.close;
   assign reset_state_bit = q_reg.rs;
   assign cycle_state_bit = q_reg.cy;
   assign lockout_state_bit = q_reg.lo;
   assign shot_indicator_bit = q_reg.sh;
   assign s_axi_awready = !q_reg.aw_got;
   assign s_axi_wready = !q_reg.w_got;
   assign s_axi_bvalid = q_reg.bvalid;
   assign s_axi_bresp = q_reg.bresp;
   assign s_axi_arready = !q_reg.rvalid;
   assign s_axi_rvalid = q_reg.rvalid;
   assign s_axi_rdata = q_reg.rdata;
   assign s_axi_rresp = q_reg.rresp;

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------
   one_state_a: assert property (@(posedge clk_sys) disable iff (rst)
      $onehot({q_reg.rs, q_reg.cy, q_reg.lo})) else $error("state bits not one-hot");
   lo_open_a: assert property (@(posedge clk_sys) disable iff (rst)
      q_reg.lo && !brk_closed |=> q_reg.lo) else $error("lockout left while open");
   rs_timed_a: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(q_reg.rs) |-> $past(q_reg.rst_cnt) >= $past(q_reg.rsti_set))
      else $error("reset before interval");
   trip_fol_a: assert property (@(posedge clk_sys) disable iff (rst)
      trip_out == $past(trip_cond)) else $error("trip not following");
   rs_shot_a: assert property (@(posedge clk_sys) disable iff (rst)
      q_reg.rs |-> q_reg.shot == 3'h0) else $error("shot nonzero in reset");
   sh_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
      shot_indicator_bit == mask_bit($past(q_reg.mask), q_reg.shot))
      else $error("shot bit mismatch");
   trip_cycle_a: assert property (@(posedge clk_sys) disable iff (rst)
      q_reg.rs && trip_cond && permit |=> q_reg.cy) else $error("no cycle on trip");
   permit_lo_a: assert property (@(posedge clk_sys) disable iff (rst)
      !permit |=> q_reg.lo) else $error("no lockout without permit");
   shot_close_a: assert property (@(posedge clk_sys) disable iff (rst)
      q_reg.cy && q_reg.shot != $past(q_reg.shot) && q_reg.shot != 3'h0 |-> close_out)
      else $error("shot without close");
   cov_reclose_c: cover property (@(posedge clk_sys) $rose(q_reg.cy));
   cov_shot_c: cover property (@(posedge clk_sys) q_reg.shot == 3'h3 && q_reg.lo);
   cov_reset_c: cover property (@(posedge clk_sys) $rose(q_reg.rs));

endmodule : rss_sequencer

/* rss_breaker_model.sv */
// Behavioural circuit breaker seen through its auxiliary contact.
// Assumes trip and close coil outputs are registered on clk_sys.
`timescale 1ns/1ps

module rss_breaker_model (
   // Clock
   input wire logic clk_sys,
   // Coils
   input wire logic trip_out,
   input wire logic close_out,
   // Auxiliary contact
   output logic breaker_closed_input
);
   int dly_reg = 0;

   initial breaker_closed_input = 1'b0;

   // Trip wins over close, like a trip-free mechanism; each move takes three clocks.
   always @(posedge clk_sys) begin
      if (breaker_closed_input ? trip_out : (close_out && !trip_out)) begin
         dly_reg <= dly_reg + 1;
         if (dly_reg == 2) begin
            breaker_closed_input <= !breaker_closed_input;
            dly_reg <= 0;
         end
      end else begin
         dly_reg <= 0;
      end
   end
endmodule : rss_breaker_model

/* tb_reclose_state_sequencer.sv */
// Self-checking bench for the reclose sequencer, breaker model on the coils.
// Assumes a cycle tick every fourth clock and short interval settings.
`timescale 1ns/1ps

module tb_reclose_state_sequencer;
   logic clk_sys = 1'b0, rst = 1'b1, dcl = 1'b0, prm = 1'b0, flt = 1'b0, tick = 1'b0;
   logic trip_out, close_out, rs, cy, lo, sh, brk;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [33:0] exp_q[$];
   logic [1:0] exp_b[$];
   int err_total = 0, checked = 0, seed = 32'h419F7319, tcnt = 0, n;
   int oi[4] = '{3, 5, 7, 0};

   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      tcnt <= (tcnt + 1) % 4;
      tick <= (tcnt == 3);
   end

   rss_sequencer rss_sequencer_i (.clk_sys(clk_sys), .rst(rst), .breaker_closed_input(brk),
      .direct_close_function(dcl), .autoclose_permit(prm), .fault_release_terms(flt),
      .cycle_tick(tick), .trip_out(trip_out), .close_out(close_out), .reset_state_bit(rs),
      .cycle_state_bit(cy), .lockout_state_bit(lo), .shot_indicator_bit(sh),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   rss_breaker_model rss_breaker_model_i (.clk_sys(clk_sys), .trip_out(trip_out),
      .close_out(close_out), .breaker_closed_input(brk));

   // -----------------------------------------------------------------------
   // Checking and reporting
   // -----------------------------------------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("Counts: %0d compared, %0d mismatched", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude

   // Responses are judged only in the cycle where the handshake completes.
   always @(negedge clk_sys) begin
      if (rvalid === 1'b1 && rready) check({rresp, rdata}, exp_q.pop_front());
      if (bvalid === 1'b1 && bready) check(bresp, exp_b.pop_front());
   end

   // The whole sequence needs well under a thousand clocks; this leaves ample margin.
   initial begin
      #400_000;
      err_total++;
      conclude();
   end

   // -----------------------------------------------------------------------
   // Bus and wait tasks
   // -----------------------------------------------------------------------
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, pa, pw;
      exp_b.push_back(er);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      // Each channel is dropped only after the edge at which it was seen taken.
      while (pa || pw) begin
         @(negedge clk_sys);
         ta = pa && awready;
         tw = pw && wready;
         @(posedge clk_sys);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      do @(negedge clk_sys); while (bvalid !== 1'b1);
      @(posedge clk_sys);
      bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge clk_sys); while (arready !== 1'b1);
      @(posedge clk_sys);
      arvalid <= 1'b0;
      do @(negedge clk_sys); while (rvalid !== 1'b1);
      @(posedge clk_sys);
      rready <= 1'b0;
   endtask : axr

   function automatic logic [33:0] stw(logic t, logic [2:0] st, logic s, logic [2:0] c);
      return {2'h0, 21'h0, c, 3'h0, s, st, t};
   endfunction : stw

   task automatic wait_for(input int sel, input logic v);
      n = 0;
      while ((sel == 0 ? trip_out : sel == 1 ? close_out : sel == 2 ? brk :
              sel == 3 ? rs : lo) !== v && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 3000) check(sel, 34'h3FFFFFFFF);
   endtask : wait_for

   // One fault: trip, open, clear the fault, time the reclose, read the shot state.
   task automatic shot(input int k);
      @(posedge clk_sys) flt <= 1'b1;
      wait_for(0, 1'b1);
      check(n <= 4, 1);
      wait_for(2, 1'b0);
      @(negedge clk_sys) check({rs, cy, lo}, 3'b010);
      repeat (2 + ($random(seed) & 7)) @(posedge clk_sys);
      flt <= 1'b0;
      wait_for(0, 1'b0);
      wait_for(1, 1'b1);
      check(n >= oi[k-1] * 4 - 4 && n <= oi[k-1] * 4 + 8, 1);
      axr(rss_pkg::RSS_STAT_OFS, stw(0, 3'b010, rss_pkg::RSS_MASK_RST[4-k], k));
      wait_for(2, 1'b1);
   endtask : shot

   // -----------------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys) check(lo, 1);
      axr(rss_pkg::RSS_CTRL_OFS, {2'h0, 32'h0000_0A00});
      axr(rss_pkg::RSS_OI1_OFS, {18'h0, rss_pkg::RSS_OI1_RST});
      axr(rss_pkg::RSS_OI2_OFS, {18'h0, rss_pkg::RSS_OI2_RST});
      axr(rss_pkg::RSS_OI3_OFS, {18'h0, rss_pkg::RSS_OI3_RST});
      axr(rss_pkg::RSS_OI4_OFS, {18'h0, rss_pkg::RSS_OI4_RST});
      axr(rss_pkg::RSS_RST_OFS, {18'h0, rss_pkg::RSS_RSTI_RST});
      axr(8'h1C, {rss_pkg::RSS_RESP_SLVERR, 32'h0});
      wstrb <= 4'h1;
      axw(rss_pkg::RSS_OI1_OFS, 32'hFFFF_FF11, rss_pkg::RSS_RESP_OKAY);
      axr(rss_pkg::RSS_OI1_OFS, {18'h0, 16'h0011});
      wstrb <= 4'hF;
      for (int i = 0; i < 4; i++) axw(8'h04 + 8'(4 * i), oi[i], rss_pkg::RSS_RESP_OKAY);
      axw(rss_pkg::RSS_RST_OFS, 32'd10, rss_pkg::RSS_RESP_OKAY);
      axw(rss_pkg::RSS_STAT_OFS, 32'hFFFF_FFFF, rss_pkg::RSS_RESP_OKAY);
      axw(8'h1C, 32'h1, rss_pkg::RSS_RESP_SLVERR);
      $display("Test registers done");
      prm <= 1'b1;
      dcl <= 1'b1;
      wait_for(2, 1'b1);
      @(posedge clk_sys) dcl <= 1'b0;
      repeat (20) @(negedge clk_sys);
      check({rs, lo}, 2'b01);
      wait_for(3, 1'b1);
      check(n + 20 >= 40 && n + 20 <= 48, 1);
      check({rs, cy, lo, sh}, 4'b1000);
      $display("Test reset interval done");
      for (int k = 1; k <= 3; k++) shot(k);
      @(posedge clk_sys) flt <= 1'b1;
      wait_for(5, 1'b1);
      @(posedge clk_sys) flt <= 1'b0;
      wait_for(0, 1'b0);
      axr(rss_pkg::RSS_STAT_OFS, stw(0, 3'b100, 1, 3));
      $display("Test shot sequence done");
      axw(rss_pkg::RSS_CTRL_OFS, 32'h0000_0A01, rss_pkg::RSS_RESP_OKAY);
      wait_for(3, 1'b1);
      axr(rss_pkg::RSS_STAT_OFS, stw(0, 3'b001, 0, 0));
      shot(1);
      wait_for(3, 1'b1);
      check({rs, cy, lo, sh}, 4'b1000);
      $display("Test command close and cycle reset done");
      @(posedge clk_sys) prm <= 1'b0;
      wait_for(5, 1'b1);
      check({rs, cy, lo}, 3'b001);
      $display("Test permit removal done");
      conclude();
   end
endmodule : tb_reclose_state_sequencer
